//--- core/osdcg_core.sv
// osd character generator: page ram, bank mapping, two windows, glyph serializer, output skid buffer
`timescale 1ns/10ps
module osdcg_core #(
  parameter int PIX_DIV    = 2,
  parameter int PAGE_DEPTH = 512
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_HFLY,
  input  wire logic        I_VFLY,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [15:0] I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  output logic      [7:0]  O_REG_RDATA,
  output logic             O_REG_RVALID,
  output logic      [13:0] O_FONT_ADDR,
  input  wire logic [23:0] I_FONT_DATA,
  output logic      [8:0]  O_OSD_RGB,
  output logic             O_OSD_SEL,
  output logic             O_BLANK,
  output logic             O_PIX_VALID,
  input  wire logic        I_PIX_READY,
  output logic      [1:0]  O_OSD_GAIN
);
  localparam int PW          = $clog2(PAGE_DEPTH);
  localparam int NUM_BANKSEL = osdcg_pkg::NUM_BANKSEL;
  localparam int NUM_WIN     = osdcg_pkg::NUM_WIN;
  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [11:0] page_ram [PAGE_DEPTH];
  logic [8:0]  palette  [64];
  logic [7:0]  bank [NUM_BANKSEL], next_bank [NUM_BANKSEL];
  logic [7:0]  hstart [NUM_WIN], next_hstart [NUM_WIN];
  logic [7:0]  vstart [NUM_WIN], next_vstart [NUM_WIN];
  logic [PW-1:0] wstart [NUM_WIN], next_wstart [NUM_WIN];
  logic [1:0]  win_en, next_win_en;
  logic [7:0]  vblank, next_vblank;
  logic [7:0]  maxchr, next_maxchr;
  logic [1:0]  contrast, next_contrast;
  logic [7:0]  rdata, next_rdata;
  logic        rvalid, next_rvalid;
  logic [2:0]  hs_s, vs_s, next_hs_s, next_vs_s;
  logic        hlvl, vlvl, hlvl_d, vlvl_d, next_hlvl, next_vlvl;
  logic [7:0]  div, next_div;
  logic        pstep, line_ev, frame_ev;
  logic [10:0] hcnt, next_hcnt;
  logic [9:0]  vcnt, next_vcnt;
  osdcg_pkg::osdcg_wst_e wst [NUM_WIN], next_wst [NUM_WIN];
  logic [PW-1:0] ptr [NUM_WIN], next_ptr [NUM_WIN];
  logic [PW-1:0] base [NUM_WIN], next_base [NUM_WIN];
  logic [PW-1:0] nbase [NUM_WIN], next_nbase [NUM_WIN];
  logic [4:0]  row [NUM_WIN], next_row [NUM_WIN];
  logic [7:0]  cnt [NUM_WIN], next_cnt [NUM_WIN];
  logic [1:0]  eol_seen, next_eol_seen;
  logic [11:0] p0, p1, next_p0, next_p1;
  logic [3:0]  col, next_col, attr, next_attr;
  logic        four, next_four, cur_w, next_cur_w;
  logic [13:0] font_addr, next_font_addr;
  logic [11:0] code_w [NUM_WIN];
  logic [1:0]  try_w, show_v, vact, pend;
  logic [10:0] hpos [NUM_WIN];
  logic        fsel, show_any, osd_on, blank_now;
  logic [11:0] fcode;
  logic [3:0]  bitsel;
  logic [1:0]  cidx;
  logic [10:0] pix_in;
  logic [10:0] out_d, sk_d, next_out_d, next_sk_d;
  logic        out_v, sk_v, next_out_v, next_sk_v;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] win_addr(input int w, input logic [15:0] ofs);
    return 16'(osdcg_pkg::ADDR_WIN_BASE + 16'(w) * osdcg_pkg::WIN_STRIDE + ofs);
  endfunction

  // top code bits pick the select register, its low field is the bank
  function automatic logic [2:0] bank_of(input logic [1:0] sel);
    return bank[sel][2:0];
  endfunction

  // ----------------------------------------------------------------
  // control port: register writes and registered reads
  // ----------------------------------------------------------------
  always_comb
  begin
    next_bank     = bank;
    next_hstart   = hstart;
    next_vstart   = vstart;
    next_wstart   = wstart;
    next_win_en   = win_en;
    next_vblank   = vblank;
    next_maxchr   = maxchr;
    next_contrast = contrast;
    if (I_REG_WR)
    begin
      if (in_rng(I_REG_ADDR, osdcg_pkg::ADDR_BANK0, osdcg_pkg::ADDR_BANK3))
        next_bank[2'(I_REG_ADDR - osdcg_pkg::ADDR_BANK0)] = I_REG_WDATA;
      else if (I_REG_ADDR == osdcg_pkg::ADDR_WIN_EN)
        next_win_en = I_REG_WDATA[1:0];
      else if (I_REG_ADDR == osdcg_pkg::ADDR_CONTRAST)
        next_contrast = I_REG_WDATA[1:0];
      else if (I_REG_ADDR == osdcg_pkg::ADDR_VBLANK)
        next_vblank = I_REG_WDATA;
      else if (I_REG_ADDR == osdcg_pkg::ADDR_MAXCHR)
        next_maxchr = I_REG_WDATA;
      for (int w = 0; w < NUM_WIN; w++)
      begin
        if (I_REG_ADDR == win_addr(w, osdcg_pkg::OFS_HSTART))
          next_hstart[w] = I_REG_WDATA;
        else if (I_REG_ADDR == win_addr(w, osdcg_pkg::OFS_VSTART))
          next_vstart[w] = I_REG_WDATA;
        else if (I_REG_ADDR == win_addr(w, osdcg_pkg::OFS_ADDR_LO))
          next_wstart[w] = PW'({wstart[w][PW-1:8], I_REG_WDATA});
        else if (I_REG_ADDR == win_addr(w, osdcg_pkg::OFS_ADDR_HI))
          next_wstart[w] = PW'({I_REG_WDATA[PW-9:0], wstart[w][7:0]});
      end
    end
  end

  // reads answer one cycle later; unmapped addresses read zero
  always_comb
  begin
    next_rvalid = I_REG_RD;
    next_rdata  = osdcg_pkg::RST_ZERO;
    if (in_rng(I_REG_ADDR, osdcg_pkg::ADDR_BANK0, osdcg_pkg::ADDR_BANK3))
      next_rdata = bank[2'(I_REG_ADDR - osdcg_pkg::ADDR_BANK0)];
    else if (I_REG_ADDR == osdcg_pkg::ADDR_WIN_EN)
      next_rdata = {6'h00, win_en};
    else if (I_REG_ADDR == osdcg_pkg::ADDR_CONTRAST)
      next_rdata = {6'h00, contrast};
    else if (I_REG_ADDR == osdcg_pkg::ADDR_VBLANK)
      next_rdata = vblank;
    else if (I_REG_ADDR == osdcg_pkg::ADDR_MAXCHR)
      next_rdata = maxchr;
    else if (I_REG_ADDR == osdcg_pkg::ADDR_STATUS)
      next_rdata = {2'h0, eol_seen, wst[1] == osdcg_pkg::W_DONE, wst[0] == osdcg_pkg::W_DONE, show_v};
    else if (in_rng(I_REG_ADDR, osdcg_pkg::ADDR_PAL_LO, osdcg_pkg::ADDR_PAL_HI))
      next_rdata = I_REG_ADDR[0] ? {7'h00, palette[I_REG_ADDR[6:1]][8]} : palette[I_REG_ADDR[6:1]][7:0];
    else if (in_rng(I_REG_ADDR, osdcg_pkg::ADDR_PAGE_LO, osdcg_pkg::ADDR_PAGE_HI))
      next_rdata = I_REG_ADDR[0] ? {4'h0, page_ram[I_REG_ADDR[PW:1]][11:8]} : page_ram[I_REG_ADDR[PW:1]][7:0];
  end

  // memories are not reset; software loads them before enabling a window
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_REG_WR && in_rng(I_REG_ADDR, osdcg_pkg::ADDR_PAGE_LO, osdcg_pkg::ADDR_PAGE_HI))
    begin
      if (I_REG_ADDR[0])
        page_ram[I_REG_ADDR[PW:1]][11:8] <= I_REG_WDATA[3:0];
      else
        page_ram[I_REG_ADDR[PW:1]][7:0] <= I_REG_WDATA;
    end
    if (I_REG_WR && in_rng(I_REG_ADDR, osdcg_pkg::ADDR_PAL_LO, osdcg_pkg::ADDR_PAL_HI))
    begin
      if (I_REG_ADDR[0])
        palette[I_REG_ADDR[6:1]][8] <= I_REG_WDATA[0];
      else
        palette[I_REG_ADDR[6:1]][7:0] <= I_REG_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // flyback synchronisers and pixel divider
  // ----------------------------------------------------------------
  always_comb
  begin
    next_hs_s = {hs_s[1:0], I_HFLY};
    next_vs_s = {vs_s[1:0], I_VFLY};
    next_hlvl = (hs_s[1] == hs_s[2]) ? hs_s[2] : hlvl;
    next_vlvl = (vs_s[1] == vs_s[2]) ? vs_s[2] : vlvl;
    // the divider parks while the buffer is full so no pixel is dropped
    next_div  = (div == 8'(PIX_DIV - 1)) ? (sk_v ? div : 8'h00) : 8'(div + 8'h01);
  end
  assign pstep    = (div == 8'(PIX_DIV - 1)) && !sk_v;
  assign line_ev  = hlvl && !hlvl_d;
  assign frame_ev = vlvl && !vlvl_d;

  // ----------------------------------------------------------------
  // window fetch engine and glyph serializer
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int w = 0; w < NUM_WIN; w++)
    begin
      code_w[w] = page_ram[ptr[w]];
      hpos[w]   = 11'({hstart[w], osdcg_pkg::HPOS_PAD});
      vact[w]   = win_en[w] && (vcnt >= {2'h0, vstart[w]});
      show_v[w] = wst[w] == osdcg_pkg::W_SHOW;
      pend[w]   = vact[w] && (wst[w] == osdcg_pkg::W_WAIT) && (hcnt <= hpos[w]);
      try_w[w]  = pstep && vact[w] && (((wst[w] == osdcg_pkg::W_WAIT) && (hcnt == hpos[w])) ||
                  (show_v[w] && (col == osdcg_pkg::COL_LAST)));
    end
    show_any = |show_v;
    // the rom port serves whichever window draws or starts next
    fsel     = show_v[0] ? 1'b0 : show_v[1] ? 1'b1 : (pend[1] && (!pend[0] || hpos[1] < hpos[0]));
    fcode    = page_ram[ptr[fsel]];
    next_font_addr = {bank_of(fcode[7:6]), fcode[5:0], row[fsel]};
  end

  always_comb
  begin
    next_wst = wst;   next_ptr = ptr;     next_base = base;   next_nbase = nbase;
    next_row = row;   next_cnt = cnt;     next_eol_seen = eol_seen;
    next_p0 = p0;     next_p1 = p1;       next_col = col;     next_attr = attr;
    next_four = four; next_cur_w = cur_w; next_hcnt = hcnt;   next_vcnt = vcnt;
    if (pstep)
    begin
      next_hcnt = 11'(hcnt + 11'h001);
      if (show_any)
        next_col = (col == osdcg_pkg::COL_LAST) ? 4'h0 : 4'(col + 4'h1);
    end
    if (frame_ev)
      next_vcnt = 10'h000;
    else if (line_ev)
      next_vcnt = 10'(vcnt + 10'h001);
    if (line_ev)
      next_hcnt = 11'h000;
    for (int w = 0; w < NUM_WIN; w++)
    begin
      if (frame_ev)
      begin
        next_ptr[w] = wstart[w];
        next_base[w] = wstart[w];
        next_row[w] = 5'h00;
        next_cnt[w] = 8'h00;
        next_eol_seen[w] = 1'b0;
        next_wst[w] = osdcg_pkg::W_WAIT;
      end
      else if (line_ev)
      begin
        if (wst[w] == osdcg_pkg::W_SHOW || wst[w] == osdcg_pkg::W_LINE_END)
        begin
          if (row[w] == osdcg_pkg::ROW_LAST)
          begin
            next_row[w]  = 5'h00;
            next_base[w] = eol_seen[w] ? nbase[w] : ptr[w];
            next_ptr[w]  = eol_seen[w] ? nbase[w] : ptr[w];
          end
          else
          begin
            next_row[w] = 5'(row[w] + 5'h01);
            next_ptr[w] = base[w];
          end
          next_cnt[w] = 8'h00;
          next_eol_seen[w] = 1'b0;
          next_wst[w] = osdcg_pkg::W_WAIT;
        end
      end
      else if (try_w[w])
      begin
        // terminators only count when reached via the first select register
        if (code_w[w][7:6] == osdcg_pkg::SEL_FIRST && code_w[w][7:0] == osdcg_pkg::CODE_EOS)
          next_wst[w] = osdcg_pkg::W_DONE;
        else if (code_w[w][7:6] == osdcg_pkg::SEL_FIRST && code_w[w][7:0] == osdcg_pkg::CODE_EOL)
        begin
          next_wst[w] = osdcg_pkg::W_LINE_END;
          next_eol_seen[w] = 1'b1;
          next_nbase[w] = PW'(ptr[w] + 1'b1);
        end
        else if (cnt[w] == maxchr)
          next_wst[w] = osdcg_pkg::W_LINE_END;
        else
        begin
          next_wst[w] = osdcg_pkg::W_SHOW;
          next_ptr[w] = PW'(ptr[w] + 1'b1);
          next_cnt[w] = 8'(cnt[w] + 8'h01);
          next_p0 = I_FONT_DATA[11:0];
          next_p1 = I_FONT_DATA[23:12];
          next_col = 4'h0;
          next_attr = code_w[w][11:8];
          next_four = (bank_of(code_w[w][7:6]) == osdcg_pkg::BANK_4C_A) ||
                      (bank_of(code_w[w][7:6]) == osdcg_pkg::BANK_4C_B);
          next_cur_w = 1'(w);
        end
      end
    end
  end

  // pixel colour and switch word; msb of a glyph row is the leftmost pixel
  always_comb
  begin
    bitsel    = 4'(osdcg_pkg::COL_LAST - col);
    cidx      = four ? {p1[bitsel], p0[bitsel]} : {1'b0, p0[bitsel]};
    blank_now = hlvl || (vcnt < {2'h0, vblank});
    osd_on    = show_any && !blank_now;
    pix_in    = {blank_now, osd_on, osd_on ? palette[{attr, cidx}] : 9'h000};
  end

  // ----------------------------------------------------------------
  // two-entry skid buffer toward the dacs
  // ----------------------------------------------------------------
  always_comb
  begin
    next_out_v = out_v; next_out_d = out_d;
    next_sk_v  = sk_v;  next_sk_d  = sk_d;
    if (!out_v || I_PIX_READY)
    begin
      next_out_v = sk_v || pstep;
      next_out_d = sk_v ? sk_d : pix_in;
      next_sk_v  = sk_v && pstep;
      next_sk_d  = pix_in;
    end
    else if (pstep)
    begin
      next_sk_v = 1'b1;
      next_sk_d = pix_in;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      for (int i = 0; i < NUM_BANKSEL; i++) bank[i] <= osdcg_pkg::RST_ZERO;
      for (int w = 0; w < NUM_WIN; w++)
      begin
        hstart[w] <= osdcg_pkg::RST_ZERO; vstart[w] <= osdcg_pkg::RST_ZERO;
        wstart[w] <= '0; ptr[w] <= '0; base[w] <= '0; nbase[w] <= '0;
        row[w] <= 5'h00; cnt[w] <= 8'h00; wst[w] <= osdcg_pkg::W_DONE;
      end
      win_en <= 2'h0; vblank <= osdcg_pkg::RST_VBLANK; maxchr <= osdcg_pkg::RST_MAXCHR;
      contrast <= 2'h0; rdata <= osdcg_pkg::RST_ZERO; rvalid <= 1'b0;
      hs_s <= 3'h0; vs_s <= 3'h0; hlvl <= 1'b0; vlvl <= 1'b0; hlvl_d <= 1'b0; vlvl_d <= 1'b0;
      div <= 8'h00; hcnt <= 11'h000; vcnt <= 10'h000; eol_seen <= 2'h0;
      p0 <= 12'h000; p1 <= 12'h000; col <= 4'h0; attr <= 4'h0; four <= 1'b0; cur_w <= 1'b0;
      font_addr <= 14'h0000; out_v <= 1'b0; out_d <= 11'h000; sk_v <= 1'b0; sk_d <= 11'h000;
    end
    else
    begin
      bank <= next_bank; hstart <= next_hstart; vstart <= next_vstart; wstart <= next_wstart;
      win_en <= next_win_en; vblank <= next_vblank; maxchr <= next_maxchr;
      contrast <= next_contrast;
      rdata <= next_rdata; rvalid <= next_rvalid;
      hs_s <= next_hs_s; vs_s <= next_vs_s; hlvl <= next_hlvl; vlvl <= next_vlvl;
      hlvl_d <= hlvl; vlvl_d <= vlvl; div <= next_div; hcnt <= next_hcnt; vcnt <= next_vcnt;
      wst <= next_wst; ptr <= next_ptr; base <= next_base; nbase <= next_nbase;
      row <= next_row; cnt <= next_cnt; eol_seen <= next_eol_seen;
      p0 <= next_p0; p1 <= next_p1; col <= next_col; attr <= next_attr;
      four <= next_four; cur_w <= next_cur_w; font_addr <= next_font_addr;
      out_v <= next_out_v; out_d <= next_out_d; sk_v <= next_sk_v; sk_d <= next_sk_d;
    end
  end

  assign O_REG_RDATA  = rdata;
  assign O_REG_RVALID = rvalid;
  assign O_FONT_ADDR  = font_addr;
  assign O_OSD_GAIN   = contrast;
  assign O_PIX_VALID  = out_v;
  assign {O_BLANK, O_OSD_SEL, O_OSD_RGB} = out_d;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);

  property p_eos_ends;
    !frame_ev && !line_ev && try_w[0] && code_w[0][7:0] == osdcg_pkg::CODE_EOS |=> wst[0] == osdcg_pkg::W_DONE;
  endproperty
  a_eos_ends: assert property (p_eos_ends) else $error("end-of-screen did not close window");

  property p_eol_stops;
    !frame_ev && !line_ev && try_w[0] && code_w[0][7:0] == osdcg_pkg::CODE_EOL
      |=> wst[0] == osdcg_pkg::W_LINE_END && eol_seen[0];
  endproperty
  a_eol_stops: assert property (p_eol_stops) else $error("end-of-line did not stop the row");

  property p_low_codes_shown;
    !frame_ev && !line_ev && try_w[0] && code_w[0][7:6] != osdcg_pkg::SEL_FIRST && cnt[0] != maxchr
      |=> wst[0] == osdcg_pkg::W_SHOW && ptr[0] == PW'($past(ptr[0]) + 1'b1);
  endproperty
  a_low_codes_shown: assert property (p_low_codes_shown) else $error("glyph via other select not shown");

  property p_font_bank;
    ##1 O_FONT_ADDR[13:11] == $past(bank_of(fcode[7:6])) && O_FONT_ADDR[10:5] == $past(fcode[5:0]);
  endproperty
  a_font_bank: assert property (p_font_bank) else $error("font address not formed from bank and code");

  property p_cell_bounds;
    col <= osdcg_pkg::COL_LAST && row[0] <= osdcg_pkg::ROW_LAST && row[1] <= osdcg_pkg::ROW_LAST;
  endproperty
  a_cell_bounds: assert property (p_cell_bounds) else $error("glyph column or row out of cell");

  property p_row_wrap;
    line_ev && !frame_ev && wst[0] == osdcg_pkg::W_LINE_END && row[0] == osdcg_pkg::ROW_LAST && eol_seen[0]
      |=> row[0] == 5'h00 && ptr[0] == $past(nbase[0]) && wst[0] == osdcg_pkg::W_WAIT;
  endproperty
  a_row_wrap: assert property (p_row_wrap) else $error("next stored line not taken after last row");

  property p_blank_no_osd;
    O_PIX_VALID && O_BLANK |-> !O_OSD_SEL && O_OSD_RGB == 9'h000;
  endproperty
  a_blank_no_osd: assert property (p_blank_no_osd) else $error("osd shown during blanking");

  property p_buffer_holds;
    O_PIX_VALID && !I_PIX_READY |=> O_PIX_VALID && $stable(out_d);
  endproperty
  a_buffer_holds: assert property (p_buffer_holds) else $error("stalled pixel changed or dropped");

  property p_four_color;
    show_any && !four |-> cidx[1] == 1'b0;
  endproperty
  a_four_color: assert property (p_four_color) else $error("two-color glyph used plane one");
endmodule

//--- inc/osdcg_pkg.sv
// shared constants, register map and state type of the osd character generator
package osdcg_pkg;
  // ----------------------------------------------------------------
  // character cell and code space
  // ----------------------------------------------------------------
  localparam int         CHAR_W      = 12;
  localparam int         CHAR_H      = 18;
  localparam logic [3:0] COL_LAST    = 4'hB;
  localparam logic [4:0] ROW_LAST    = 5'h11;
  localparam logic [7:0] CODE_EOS    = 8'h00;
  localparam logic [7:0] CODE_EOL    = 8'h01;
  localparam logic [1:0] SEL_FIRST   = 2'h0;
  localparam logic [2:0] BANK_4C_A   = 3'h3;
  localparam logic [2:0] BANK_4C_B   = 3'h7;
  localparam int         NUM_BANKSEL = 4;
  localparam int         NUM_WIN     = 2;
  localparam logic [1:0] HPOS_PAD    = 2'h0;
  // ----------------------------------------------------------------
  // register map (byte addresses on the control port)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_BANK0    = 16'h8427;
  localparam logic [15:0] ADDR_BANK3    = 16'h842A;
  localparam logic [15:0] ADDR_WIN_EN   = 16'h8430;
  localparam logic [15:0] ADDR_WIN_BASE = 16'h8431;
  localparam logic [15:0] WIN_STRIDE    = 16'h0004;
  localparam logic [15:0] OFS_HSTART    = 16'h0000;
  localparam logic [15:0] OFS_VSTART    = 16'h0001;
  localparam logic [15:0] OFS_ADDR_LO   = 16'h0002;
  localparam logic [15:0] OFS_ADDR_HI   = 16'h0003;
  localparam logic [15:0] ADDR_CONTRAST = 16'h8440;
  localparam logic [15:0] ADDR_VBLANK   = 16'h8441;
  localparam logic [15:0] ADDR_STATUS   = 16'h8442;
  localparam logic [15:0] ADDR_MAXCHR   = 16'h8443;
  localparam logic [15:0] ADDR_PAL_LO   = 16'h8500;
  localparam logic [15:0] ADDR_PAL_HI   = 16'h857F;
  localparam logic [15:0] ADDR_PAGE_LO  = 16'h8800;
  localparam logic [15:0] ADDR_PAGE_HI  = 16'h8BFF;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_MAXCHR = 8'h40;
  localparam logic [7:0] RST_VBLANK = 8'h10;
  // per-window display state
  typedef enum logic [1:0] {
    W_WAIT     = 2'b00,
    W_SHOW     = 2'b01,
    W_LINE_END = 2'b10,
    W_DONE     = 2'b11
  } osdcg_wst_e;
endpackage

//--- sim/osdcg_font_model.sv
// font rom stand-in for the osd character generator
`timescale 1ns/10ps
module osdcg_font_model (
  input  wire logic        i_clk,
  input  wire logic [13:0] i_addr,
  output logic      [23:0] o_data
);
  // one-cycle latency; every bank, glyph and row gives its own two-plane pattern
  always_ff @(posedge i_clk)
    o_data <= {i_addr[11:0] ^ 12'hA5C, i_addr[13:2]};
endmodule

//--- sim/tb_osd_character_generator.sv
// self-checking bench for the osd character generator
`timescale 1ns/10ps
module tb_osd_character_generator;
  localparam logic [7:0] CODES[7] = '{8'h41, 8'h85, 8'hC6, 8'h02, 8'h01, 8'h7F, 8'h00};
  logic        clk, rst_n, hfly, vfly, wr, rd, raster, ready, rvalid, pvalid, osd_sel, blank, p_valid, p_ready;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [13:0] font_addr;
  logic [23:0] font_data;
  logic [8:0]  rgb, last_g;
  logic [1:0]  gain;
  logic [10:0] p_word;
  logic [8:0]  glyphs[$];
  logic [2:0]  bank[4];
  logic [31:0] seed, sk;
  logic [3:0]  attr_exp;
  int          n_fail, n_compared, pc, ln, n_osd;

  osdcg_core #(.PIX_DIV(2), .PAGE_DEPTH(512)) dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_HFLY(hfly),
    .I_VFLY(vfly), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_FONT_ADDR(font_addr), .I_FONT_DATA(font_data),
    .O_OSD_RGB(rgb), .O_OSD_SEL(osd_sel), .O_BLANK(blank), .O_PIX_VALID(pvalid),
    .I_PIX_READY(ready), .O_OSD_GAIN(gain));
  osdcg_font_model rom (.i_clk(clk), .i_addr(font_addr), .o_data(font_data));

  // 250 MHz reference clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // expected font bank and index for a page code
  function automatic logic [8:0] glyph_of(input logic [7:0] code);
    return {bank[code[7:6]], code[5:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobes, driven on the falling edge so the rising edge sees them settled
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    check({rvalid, rdata}, {1'b1, exp});
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // sink with random stalls; a stalled word must stand unchanged
  always @(negedge clk)
  begin
    if (rst_n && p_valid && !p_ready)
      check({pvalid, osd_sel, blank, rgb}, {1'b1, p_word});
    // an osd word carries the page attribute and the palette pattern loaded below
    if (rst_n && pvalid && osd_sel)
    begin
      n_osd++;
      check({blank, rgb[8:5], rgb[3:0]}, {1'b0, attr_exp, 4'h5});
    end
    p_valid = pvalid;
    p_word = {osd_sel, blank, rgb};
    sk = xs(sk);
    ready = sk[0] | sk[1];
    // the ready just driven is the one the next rising edge samples
    p_ready = ready;
  end

  // record each new glyph fetched; row changes alone are not new glyphs
  always @(negedge clk)
    if (raster && font_addr[13:5] != last_g)
    begin
      glyphs.push_back(font_addr[13:5]);
      last_g = font_addr[13:5];
    end

  // 200-clock lines, 10-clock horizontal flyback, vertical flyback over the first two lines
  always @(negedge clk)
    if (raster)
    begin
      pc = (pc == 199) ? 0 : pc + 1;
      ln = (pc == 0) ? ln + 1 : ln;
      hfly = (pc < 10);
      vfly = (ln < 2);
    end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hfly, vfly, wr, rd, raster, p_valid, rst_n} = '0;
    {ready, p_ready} = 2'b11;
    {addr, wdata, last_g, p_word} = '0;
    {seed, sk, pc, ln, n_fail, n_compared} = {32'd58, 32'd58 ^ 32'h5A5A, 128'h0};
    n_osd = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(osdcg_pkg::ADDR_VBLANK, osdcg_pkg::RST_VBLANK);
    rd_chk(osdcg_pkg::ADDR_MAXCHR, osdcg_pkg::RST_MAXCHR);
    rd_chk(16'h8000, 8'h00);
    for (int g = 0; g < 4; g++)
    begin
      reg_wr(osdcg_pkg::ADDR_CONTRAST, 8'(g));
      @(negedge clk);
      check(16'(gain), 16'(g));
    end
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      bank[i] = (i == 1) ? bank[0] : seed[2:0];
      reg_wr(osdcg_pkg::ADDR_BANK0 + 16'(i), {5'h0, bank[i]});
      rd_chk(osdcg_pkg::ADDR_BANK0 + 16'(i), {5'h0, bank[i]});
    end
    // colours 1 and 3 mirror 0 and 2, so only the upper plane picks a colour
    for (int p = 0; p < 64; p++)
    begin
      reg_wr(osdcg_pkg::ADDR_PAL_LO + 16'(2 * p), {p[4:1], 4'h5});
      reg_wr(osdcg_pkg::ADDR_PAL_LO + 16'(2 * p + 1), {7'h00, p[5]});
    end
    attr_exp = seed[7:4];
    for (int i = 0; i < 7; i++)
    begin
      reg_wr(osdcg_pkg::ADDR_PAGE_LO + 16'(2 * i), CODES[i]);
      reg_wr(osdcg_pkg::ADDR_PAGE_LO + 16'(2 * i + 1), {4'h0, attr_exp});
    end
    reg_wr(osdcg_pkg::ADDR_PAGE_HI - 16'h1, 8'h5C);
    rd_chk(osdcg_pkg::ADDR_PAGE_HI - 16'h1, 8'h5C);
    rd_chk(osdcg_pkg::ADDR_PAGE_LO + 16'h2, 8'h85);
    reg_wr(osdcg_pkg::ADDR_VBLANK, 8'h00);
    reg_wr(osdcg_pkg::ADDR_WIN_BASE, 8'h02);
    reg_wr(osdcg_pkg::ADDR_WIN_BASE + 16'h1, 8'h01);
    reg_wr(osdcg_pkg::ADDR_WIN_EN, 8'h01);
    raster = 1'b1;
    for (int t = 0; t < 20000 && glyphs.size() < 4; t++)
      @(negedge clk);
    if (glyphs.size() < 4)
      n_fail++;
    else
      for (int i = 0; i < 4; i++)
        check(16'(glyphs[i]), 16'(glyph_of(CODES[i])));
    repeat (12000) @(negedge clk);
    // after 18 rows the entry behind the end-of-line code is drawn, then end-of-screen
    if (glyphs.size() > 5)
      check(16'(glyphs[glyphs.size() - 2]), 16'(glyph_of(CODES[5])));
    else
      n_fail++;
    check(16'(n_osd > 0), 16'h0001);
    rd_chk(osdcg_pkg::ADDR_STATUS, 8'h04);
    complete_run();
  end
endmodule
